// File: logic/epil_pkg.sv
// constants for the external pin interrupt latch block
// assumes an 8-bit register port and a single bus clock domain
// Functional notes
// - enable bit selects interrupt pin function
// - falling edge sets request latch
// - vector fetch acknowledge clears the latch
// - software acknowledge write clears the latch
// - reset: edge-only mode, latch cleared
// - mask bit blocks request to priority logic
// - level mode: request held while low
// - acknowledge and pin high in any order
// - falling edge after acknowledge sets again
// - edge mode: acknowledge clears at once
// - pending flag ignores the mask bit
// - acknowledge bit write-only, reads zero
// - mask bit read/write, one disables
// - mode bit: one adds low levels
// - unmasked request wakes from wait/stop
// - break state protects status without enable
// - break clear enable allows lasting clears
// - pin test reads one when disabled
// - port A bit two reads zero when enabled
// - pullup on unless pullup-disable bit set
package epil_pkg;
  // register addresses
  localparam logic [7:0] EPIL_SCR_ADDR  = 8'h1d; // status and control
  localparam logic [7:0] EPIL_CFG2_ADDR = 8'h1e; // system_config_two
  localparam logic [7:0] EPIL_BFC_ADDR  = 8'h1f; // break_flag_control
  // system_config_two fields
  localparam int EPIL_CFG2_EN_BIT  = 0; // pin_function_enable
  localparam int EPIL_CFG2_PUD_BIT = 1; // pin_pullup_disable
  // status and control fields
  localparam int EPIL_SCR_MODE_BIT = 0; // level-and-edge select
  localparam int EPIL_SCR_MASK_BIT = 1; // request_mask
  localparam int EPIL_SCR_ACK_BIT  = 2; // write-only acknowledge
  localparam int EPIL_SCR_FLAG_BIT = 3; // request_pending_flag
  // break_flag_control field
  localparam int EPIL_BFC_CLR_EN_BIT = 7; // break_clear_enable
  // port A bit shared with the pin
  localparam int EPIL_PTA_SHARED_BIT = 2;
  // reset values
  localparam logic [7:0] EPIL_CFG2_RST = 8'h00;
  localparam logic [7:0] EPIL_BFC_RST  = 8'h00;
  localparam logic [7:0] EPIL_RD_RST   = 8'h00;
endpackage

// File: logic/epil_evt_if.sv
// carrier between pin sampler, request latch and top
// assumes all members live in the bus clock domain
`timescale 1ns/1ps
interface epil_evt_if;
  logic pin_low;  // synced pin level, active low pin seen low
  logic fall;     // one-cycle falling edge pulse
  logic ack;      // one-cycle acknowledge pulse
  logic mode;     // level-and-edge sensitivity
  logic enable;   // pin function enable
  logic pending;  // request latch state
  modport sync_mp  (output pin_low, output fall);
  modport latch_mp (input pin_low, input fall, input ack,
                    input mode, input enable, output pending);
  modport top_mp   (input pin_low, input fall, input pending,
                    output ack, output mode, output enable);
endinterface

// File: logic/epil_pin_sync.sv
// two-flop synchroniser and falling edge detector for the pin
// assumes the pin is asynchronous and idles high on its pullup
`timescale 1ns/1ps
module epil_pin_sync
  import epil_pkg::*;
(
  input  wire logic  clk_in,
  input  wire logic  nrst_in,
  input  wire logic  pin_n_in,
  epil_evt_if.sync_mp evt
);
  // s1 first stage, s2 synced, s3 previous synced sample
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } epil_sync_s;

  epil_sync_s st_ff;  // registered state
  epil_sync_s nxt_st; // next state

  // shift chain; s1 only feeds s2
  always_comb
  begin
    nxt_st    = st_ff;
    nxt_st.s1 = pin_n_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
  end

  // reset to high so no false edge after release
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      st_ff <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1};
    else
      st_ff <= nxt_st;
  end

  // edge from two synced samples only
  assign evt.pin_low = ~st_ff.s2;
  assign evt.fall    = st_ff.s3 & ~st_ff.s2;
endmodule

// File: logic/epil_req_latch.sv
// request latch with edge-only and level-and-edge modes
// assumes acknowledge is already gated for the break state
`timescale 1ns/1ps
module epil_req_latch
  import epil_pkg::*;
(
  input  wire logic   clk_in,
  input  wire logic   nrst_in,
  epil_evt_if.latch_mp evt
);
  // latch plus memory of an acknowledge taken while low
  typedef struct packed {
    logic latch;
    logic ack_done;
  } epil_latch_s;

  epil_latch_s st_ff;  // registered state
  epil_latch_s nxt_st; // next state
  logic        low_en; // pin low and function on
  logic        set_ev; // set condition

  always_comb
  begin
    nxt_st = st_ff;
    low_en = evt.pin_low & evt.enable;
    // low level counts only until acknowledged
    set_ev = (evt.fall & evt.enable)
           | (evt.mode & low_en & ~st_ff.ack_done);
    if (!evt.mode)
    begin
      // edge only: acknowledge clears at once
      nxt_st.ack_done = 1'b0;
      if (evt.ack)
        nxt_st.latch = 1'b0;
    end
    else if (evt.ack && !low_en)
      nxt_st.latch = 1'b0;
    else if (evt.ack)
      nxt_st.ack_done = st_ff.latch;
    else if (st_ff.ack_done && !low_en)
    begin
      // pin returned high after acknowledge
      nxt_st.latch    = 1'b0;
      nxt_st.ack_done = 1'b0;
    end
    // a new edge re-arms, set wins over clear
    if (evt.fall & evt.enable)
      nxt_st.ack_done = 1'b0;
    if (set_ev)
      nxt_st.latch = 1'b1;
  end

  // reset clears latch even with the pin low
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      st_ff <= '{latch: 1'b0, ack_done: 1'b0};
    else
      st_ff <= nxt_st;
  end

  assign evt.pending = st_ff.latch;
endmodule

// File: logic/epil_top.sv
// external pin interrupt latch: registers, gating, pin views
// assumes a one-cycle strobe register port, one bus clock,
// and a cpu that pulses vector_fetch_in on this vector
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module epil_top
  import epil_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic       irq_pin_n_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rd_data_out,
  input  wire logic       vector_fetch_in,
  input  wire logic       break_state_in,
  input  wire logic [7:0] port_a_data_in,
  output logic      [7:0] port_a_read_out,
  output logic            pin_level_test_out,
  output logic            irq_req_out,
  output logic            wake_out,
  output logic            pullup_en_out,
  output logic            pin_func_en_out
);
  // all software-visible state of the block except the request latch
  typedef struct packed {
    logic [7:0] cfg2;    // system_config_two
    logic       mask;    // request_mask
    logic       mode;    // sensitivity select
    logic       clr_en;  // break_clear_enable
    logic [7:0] rd_data; // read data, one cycle late
  } epil_top_s;

  epil_top_s st_ff;  // registered state
  epil_top_s nxt_st; // next state

  // decoded strobes
  logic wr_scr;   // write to status and control
  logic wr_cfg2;  // write to system_config_two
  logic wr_bfc;   // write to break_flag_control
  logic ack_sw;   // software acknowledge after break gate
  logic ack_any;  // combined acknowledge pulse

  epil_evt_if evt ();

  // sampler feeds edge and level to the latch
  epil_pin_sync u_sync (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .pin_n_in (irq_pin_n_in),
    .evt      (evt)
  );

  // request latch
  epil_req_latch u_latch (
    .clk_in  (clk_in),
    .nrst_in (nrst_in),
    .evt     (evt)
  );

  // address match used by read and write decode
  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] reg_addr);
    hit = (a == reg_addr);
  endfunction

  // read mux; unmapped addresses read zero
  function automatic logic [7:0] rd_mux(input logic [7:0] a,
                                        input epil_top_s s,
                                        input logic pend);
    logic [7:0] v;
    v = 8'h00;
    if (hit(a, EPIL_SCR_ADDR))
    begin
      v[EPIL_SCR_FLAG_BIT] = pend;
      v[EPIL_SCR_ACK_BIT]  = 1'b0;
      v[EPIL_SCR_MASK_BIT] = s.mask;
      v[EPIL_SCR_MODE_BIT] = s.mode;
    end
    else if (hit(a, EPIL_CFG2_ADDR))
      v = s.cfg2;
    else if (hit(a, EPIL_BFC_ADDR))
      v[EPIL_BFC_CLR_EN_BIT] = s.clr_en;
    rd_mux = v;
  endfunction

  // write decode and acknowledge generation
  always_comb
  begin
    wr_scr  = wr_in & hit(addr_in, EPIL_SCR_ADDR);
    wr_cfg2 = wr_in & hit(addr_in, EPIL_CFG2_ADDR);
    wr_bfc  = wr_in & hit(addr_in, EPIL_BFC_ADDR);
    // break state shields the latch unless clear enable set
    ack_sw  = wr_scr & wr_data_in[EPIL_SCR_ACK_BIT]
            & (~break_state_in | st_ff.clr_en);
    // vector fetch and software write act alike
    ack_any = ack_sw | vector_fetch_in;
  end

  // register updates
  always_comb
  begin
    nxt_st = st_ff;
    if (wr_cfg2)
      nxt_st.cfg2 = wr_data_in;
    if (wr_scr)
    begin
      nxt_st.mask = wr_data_in[EPIL_SCR_MASK_BIT];
      nxt_st.mode = wr_data_in[EPIL_SCR_MODE_BIT];
    end
    if (wr_bfc)
      nxt_st.clr_en = wr_data_in[EPIL_BFC_CLR_EN_BIT];
    // data stands only in the cycle after the read
    if (rd_in)
      nxt_st.rd_data = rd_mux(addr_in, st_ff, evt.pending);
    else
      nxt_st.rd_data = EPIL_RD_RST;
  end

  // reset: edge-only, unmasked, pullup on, function off
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      st_ff.cfg2    <= EPIL_CFG2_RST;
      st_ff.mask    <= 1'b0;
      st_ff.mode    <= 1'b0;
      st_ff.clr_en  <= 1'b0;
      st_ff.rd_data <= EPIL_RD_RST;
    end
    else
      st_ff <= nxt_st;
  end

  // controls into the latch
  assign evt.ack    = ack_any;
  assign evt.mode   = st_ff.mode;
  assign evt.enable = st_ff.cfg2[EPIL_CFG2_EN_BIT];

  // outputs
  assign rd_data_out     = st_ff.rd_data;
  assign pin_func_en_out = evt.enable;
  // request reaches priority logic only unmasked
  assign irq_req_out = evt.pending & ~st_ff.mask;
  // block stays clocked in low power; same term wakes
  assign wake_out = irq_req_out;
  assign pullup_en_out = ~st_ff.cfg2[EPIL_CFG2_PUD_BIT];
  // pin test sees one when the function is off
  assign pin_level_test_out = ~evt.enable
                            | ~evt.pin_low;

  // shared port bit hidden while the pin is taken
  always_comb
  begin
    port_a_read_out = port_a_data_in;
    if (evt.enable)
      port_a_read_out[EPIL_PTA_SHARED_BIT] = 1'b0;
  end

  // edge mode acknowledge clears on the next clock edge
  property p_ack_clears;
    @(posedge clk_in) disable iff (!nrst_in)
    (ack_any && !st_ff.mode && !evt.fall) |=> !evt.pending;
  endproperty
  a_ack_clears: assert property (p_ack_clears)
    else $error("edge mode acknowledge did not clear");

  // an enabled falling edge always latches
  property p_fall_sets;
    @(posedge clk_in) disable iff (!nrst_in)
    (evt.fall && evt.enable) |=> evt.pending;
  endproperty
  a_fall_sets: assert property (p_fall_sets)
    else $error("falling edge not latched");

  // masked request never reaches priority logic
  property p_mask_gate;
    @(posedge clk_in) disable iff (!nrst_in)
    st_ff.mask |-> !irq_req_out;
  endproperty
  a_mask_gate: assert property (p_mask_gate)
    else $error("masked request forwarded");

  // level mode holds request while pin is low
  property p_level_hold;
    @(posedge clk_in) disable iff (!nrst_in)
    (st_ff.mode && evt.pending && evt.pin_low && evt.enable)
      |=> evt.pending;
  endproperty
  a_level_hold: assert property (p_level_hold)
    else $error("level request dropped while low");

  // acknowledge bit reads back as zero
  property p_ack_reads_zero;
    @(posedge clk_in) disable iff (!nrst_in)
    (rd_in && addr_in == EPIL_SCR_ADDR)
      |=> !rd_data_out[EPIL_SCR_ACK_BIT];
  endproperty
  a_ack_reads_zero: assert property (p_ack_reads_zero)
    else $error("acknowledge bit read as one");

  // flag reads latch state whatever the mask
  property p_flag_view;
    @(posedge clk_in) disable iff (!nrst_in)
    (rd_in && addr_in == EPIL_SCR_ADDR)
      |=> rd_data_out[EPIL_SCR_FLAG_BIT] == $past(evt.pending);
  endproperty
  a_flag_view: assert property (p_flag_view)
    else $error("pending flag does not match latch");

  // break without clear enable leaves the latch standing
  property p_break_protect;
    @(posedge clk_in) disable iff (!nrst_in)
    (wr_scr && wr_data_in[EPIL_SCR_ACK_BIT] && break_state_in
      && !st_ff.clr_en && !vector_fetch_in && evt.pending)
      |=> evt.pending;
  endproperty
  a_break_protect: assert property (p_break_protect)
    else $error("latch cleared in protected break");

  // shared port bit reads zero when enabled
  property p_pta_zero;
    @(posedge clk_in) disable iff (!nrst_in)
    evt.enable |-> !port_a_read_out[EPIL_PTA_SHARED_BIT];
  endproperty
  a_pta_zero: assert property (p_pta_zero)
    else $error("shared port bit not zero");

  // pin test forced high when disabled
  property p_pin_test;
    @(posedge clk_in) disable iff (!nrst_in)
    !evt.enable |-> pin_level_test_out;
  endproperty
  a_pin_test: assert property (p_pin_test)
    else $error("pin test not high while disabled");

  // pullup follows the disable bit written
  property p_pullup;
    @(posedge clk_in) disable iff (!nrst_in)
    (wr_cfg2) |=> pullup_en_out
      == !$past(wr_data_in[EPIL_CFG2_PUD_BIT]);
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pullup does not follow config");

  // disabled function never raises a request
  property p_off_no_set;
    @(posedge clk_in) disable iff (!nrst_in)
    (!evt.enable && !evt.pending) |=> !evt.pending;
  endproperty
  a_off_no_set: assert property (p_off_no_set)
    else $error("request set while function off");

  // vector fetch alone clears in edge mode
  property p_fetch_clears;
    @(posedge clk_in) disable iff (!nrst_in)
    (vector_fetch_in && !st_ff.mode && !evt.fall) |=> !evt.pending;
  endproperty
  a_fetch_clears: assert property (p_fetch_clears)
    else $error("vector fetch did not clear");

  // software acknowledge outside break clears in edge mode
  property p_sw_ack_clears;
    @(posedge clk_in) disable iff (!nrst_in)
    (wr_scr && wr_data_in[EPIL_SCR_ACK_BIT] && !break_state_in
      && !st_ff.mode && !evt.fall) |=> !evt.pending;
  endproperty
  a_sw_ack_clears: assert property (p_sw_ack_clears)
    else $error("software acknowledge did not clear");

  // level mode: acknowledge with pin high clears at once
  property p_level_ack_high;
    @(posedge clk_in) disable iff (!nrst_in)
    (st_ff.mode && ack_any && !(evt.pin_low && evt.enable))
      |=> !evt.pending;
  endproperty
  a_level_ack_high: assert property (p_level_ack_high)
    else $error("level request kept after ack with pin high");

  // clear enable lets a break acknowledge clear
  property p_break_clear;
    @(posedge clk_in) disable iff (!nrst_in)
    (wr_scr && wr_data_in[EPIL_SCR_ACK_BIT] && break_state_in
      && st_ff.clr_en && !st_ff.mode && !evt.fall) |=> !evt.pending;
  endproperty
  a_break_clear: assert property (p_break_clear)
    else $error("enabled break acknowledge did not clear");

  // unmasked request reaches priority logic
  property p_unmask_pass;
    @(posedge clk_in) disable iff (!nrst_in)
    (evt.pending && !st_ff.mask) |-> irq_req_out;
  endproperty
  a_unmask_pass: assert property (p_unmask_pass)
    else $error("unmasked request not forwarded");

  // an unmasked request also asks for wake-up
  property p_wake;
    @(posedge clk_in) disable iff (!nrst_in)
    (evt.pending && !st_ff.mask) |-> wake_out;
  endproperty
  a_wake: assert property (p_wake)
    else $error("unmasked request gives no wake");

  // pin test shows the synced level when enabled
  property p_pin_test_on;
    @(posedge clk_in) disable iff (!nrst_in)
    evt.enable |-> pin_level_test_out == !evt.pin_low;
  endproperty
  a_pin_test_on: assert property (p_pin_test_on)
    else $error("pin test does not follow pin");

  // port view passes raw data while function off
  property p_pta_pass;
    @(posedge clk_in) disable iff (!nrst_in)
    !evt.enable |-> port_a_read_out == port_a_data_in;
  endproperty
  a_pta_pass: assert property (p_pta_pass)
    else $error("port view altered while function off");

  // mode bit takes what was written
  property p_mode_rw;
    @(posedge clk_in) disable iff (!nrst_in)
    wr_scr |=> st_ff.mode == $past(wr_data_in[EPIL_SCR_MODE_BIT]);
  endproperty
  a_mode_rw: assert property (p_mode_rw)
    else $error("mode bit not written");

  // main scenarios
  c_edge_ack: cover property (@(posedge clk_in)
    disable iff (!nrst_in) evt.pending && !st_ff.mode
    ##1 ack_any ##1 !evt.pending);
  c_level_order: cover property (@(posedge clk_in)
    disable iff (!nrst_in) st_ff.mode && ack_any
    && evt.pin_low ##[1:20] !evt.pending);
  c_break_block: cover property (@(posedge clk_in)
    disable iff (!nrst_in) ack_sw == 1'b0 && wr_scr
    && break_state_in);
  c_break_clear: cover property (@(posedge clk_in)
    disable iff (!nrst_in) ack_sw && break_state_in);
  c_mask_poll: cover property (@(posedge clk_in)
    disable iff (!nrst_in) st_ff.mask && evt.pending && rd_in);
endmodule

// File: testbench/epil_pin_source.sv
// far-side model: an external device pulling the request pin low
// assumes the bench commands it and the block reports its pullup
`timescale 1ns/1ps
module epil_pin_source
(
  input  wire logic clk_in,
  input  wire logic low_req_in,
  input  wire logic pullup_en_in,
  output logic      pin_n_out
);
  logic float_q = 1'b0; // level of an undriven, unpulled line

  // a floating pin must not look steady, so it wanders every cycle
  always @(posedge clk_in)
  begin
    float_q <= ~float_q;
  end

  // open drain: only ever pulls low, otherwise released
  assign pin_n_out = low_req_in   ? 1'b0 :
                     pullup_en_in ? 1'b1 : float_q;
endmodule

// File: testbench/epil_top_test.sv
// self-checking bench for the external pin interrupt latch
// assumes one 200 MHz clock and the one-cycle strobe register port
`timescale 1ns/1ps
module epil_top_test;
  import epil_pkg::*;
  logic       clk_in;          // bus clock
  logic       nrst_in;         // async reset, active low
  logic       pin_n;           // request pin level
  logic       low_cmd;         // tells the device to pull low
  logic [7:0] addr_in;         // register address
  logic [7:0] wr_data_in;      // write data
  logic       wr_in;           // write strobe
  logic       rd_in;           // read strobe
  logic [7:0] rd_data_out;     // read data
  logic       vector_fetch_in; // cpu vector fetch pulse
  logic       break_state_in;  // debug break level
  logic [7:0] port_a_data_in;  // raw port data
  logic [7:0] port_a_read_out; // port view
  logic       pin_test;        // pin-high test view
  logic       irq_req;         // request to priority logic
  logic       wake;            // wake request
  logic       pullup_en;       // pullup connect
  logic       func_en;         // pin function on
  int         err_count;       // mismatches
  int         checks;          // comparisons made
  int         cyc = 0;         // cycles run

  epil_top u_epil_top (
    .clk_in             (clk_in),
    .nrst_in            (nrst_in),
    .irq_pin_n_in       (pin_n),
    .addr_in            (addr_in),
    .wr_data_in         (wr_data_in),
    .wr_in              (wr_in),
    .rd_in              (rd_in),
    .rd_data_out        (rd_data_out),
    .vector_fetch_in    (vector_fetch_in),
    .break_state_in     (break_state_in),
    .port_a_data_in     (port_a_data_in),
    .port_a_read_out    (port_a_read_out),
    .pin_level_test_out (pin_test),
    .irq_req_out        (irq_req),
    .wake_out           (wake),
    .pullup_en_out      (pullup_en),
    .pin_func_en_out    (func_en)
  );

  epil_pin_source u_epil_pin_source (
    .clk_in       (clk_in),
    .low_req_in   (low_cmd),
    .pullup_en_in (pullup_en),
    .pin_n_out    (pin_n)
  );

  // 5 ns period
  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // verdict in one place
  task automatic results();
    if (err_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // hang guard, the whole run needs well under 1000 cycles
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_count++;
      results();
    end
  end

  // one compare for every byte or flag result
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in    <= a;
    wr_data_in <= d;
    wr_in      <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe edge
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk(rd_data_out, exp);
  endtask

  // pin change plus time for two sync flops and the latch
  task automatic pin_low(input logic v);
    @(posedge clk_in);
    low_cmd <= v;
    repeat (5) @(posedge clk_in);
    #1;
  endtask

  task automatic vfetch();
    @(posedge clk_in);
    vector_fetch_in <= 1'b1;
    @(posedge clk_in);
    vector_fetch_in <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge clk_in);
    nrst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    nrst_in <= 1'b1;
    #1;
  endtask

  initial
  begin
    nrst_in = 1'b0;
    low_cmd = 1'b0;
    addr_in = 8'h00;
    wr_data_in = 8'h00;
    wr_in = 1'b0;
    rd_in = 1'b0;
    vector_fetch_in = 1'b0;
    break_state_in = 1'b0;
    port_a_data_in = 8'hff; // the only tied input
    err_count = 0;
    checks = 0;
    do_reset();
    // reset state
    chk({7'h00, pullup_en}, 8'h01);
    chk({7'h00, func_en}, 8'h00);
    chk({7'h00, pin_test}, 8'h01);
    chk(port_a_read_out, 8'hff);
    rd_chk(EPIL_SCR_ADDR, 8'h00);
    rd_chk(EPIL_CFG2_ADDR, EPIL_CFG2_RST);
    rd_chk(EPIL_BFC_ADDR, EPIL_BFC_RST);
    // function off: a fall is ignored, pin test reads high
    pin_low(1'b1);
    chk({7'h00, pin_test}, 8'h01);
    rd_chk(EPIL_SCR_ADDR, 8'h00);
    pin_low(1'b0);
    wr(EPIL_CFG2_ADDR, 8'h01);
    #1;
    chk({7'h00, func_en}, 8'h01);
    chk(port_a_read_out, 8'hfb);
    chk({7'h00, pin_test}, 8'h01);
    // edge mode: set, then ack while still low
    pin_low(1'b1);
    chk({7'h00, pin_test}, 8'h00);
    chk({6'h00, wake, irq_req}, 8'h03);
    rd_chk(EPIL_SCR_ADDR, 8'h08);
    wr(EPIL_SCR_ADDR, 8'h04);
    rd_chk(EPIL_SCR_ADDR, 8'h00);
    pin_low(1'b0);
    // masked: flag visible, no request; vector fetch clears
    wr(EPIL_SCR_ADDR, 8'h02);
    pin_low(1'b1);
    chk({6'h00, wake, irq_req}, 8'h00);
    rd_chk(EPIL_SCR_ADDR, 8'h0a);
    vfetch();
    rd_chk(EPIL_SCR_ADDR, 8'h02);
    pin_low(1'b0);
    // a fall after an ack sets the latch again
    wr(EPIL_SCR_ADDR, 8'h04);
    pin_low(1'b1);
    chk({7'h00, irq_req}, 8'h01);
    pin_low(1'b0);
    wr(EPIL_SCR_ADDR, 8'h04);
    // level mode, ack first then pin high
    wr(EPIL_SCR_ADDR, 8'h01);
    rd_chk(EPIL_SCR_ADDR, 8'h01);
    pin_low(1'b1);
    wr(EPIL_SCR_ADDR, 8'h05);
    rd_chk(EPIL_SCR_ADDR, 8'h09);
    pin_low(1'b0);
    rd_chk(EPIL_SCR_ADDR, 8'h01);
    // level mode, pin high first then vector fetch
    pin_low(1'b1);
    pin_low(1'b0);
    rd_chk(EPIL_SCR_ADDR, 8'h09);
    vfetch();
    rd_chk(EPIL_SCR_ADDR, 8'h01);
    // break state: acks ignored until clear enable set
    wr(EPIL_SCR_ADDR, 8'h00);
    pin_low(1'b1);
    @(posedge clk_in);
    break_state_in <= 1'b1;
    wr(EPIL_SCR_ADDR, 8'h04);
    rd_chk(EPIL_SCR_ADDR, 8'h08);
    wr(EPIL_BFC_ADDR, 8'h80);
    rd_chk(EPIL_BFC_ADDR, 8'h80);
    wr(EPIL_SCR_ADDR, 8'h04);
    break_state_in <= 1'b0;
    rd_chk(EPIL_SCR_ADDR, 8'h00);
    pin_low(1'b0);
    wr(EPIL_BFC_ADDR, 8'h00);
    // reset while held low in level mode, handler keeps it masked
    wr(EPIL_SCR_ADDR, 8'h03);
    pin_low(1'b1);
    chk({6'h00, wake, irq_req}, 8'h00);
    rd_chk(EPIL_SCR_ADDR, 8'h0b);
    do_reset();
    rd_chk(EPIL_SCR_ADDR, 8'h00);
    // enabling with the pin still low must not latch in edge mode
    wr(EPIL_CFG2_ADDR, 8'h01);
    rd_chk(EPIL_SCR_ADDR, 8'h00);
    pin_low(1'b0);
    // pullup disable and config readback
    wr(EPIL_CFG2_ADDR, 8'h03);
    #1;
    chk({7'h00, pullup_en}, 8'h00);
    rd_chk(EPIL_CFG2_ADDR, 8'h03);
    wr(EPIL_CFG2_ADDR, 8'h00);
    // unmapped place ignores writes, reads zero
    wr(8'h20, 8'hff);
    rd_chk(8'h20, 8'h00);
    rd_chk(EPIL_CFG2_ADDR, 8'h00);
    results();
  end
endmodule
